/* File: core/drm_rate_meas.v */
// fine data-rate measurement unit: config/action registers, gate control, result registers
// Behaviour
// RULE_01 - reference 10-160 MHz; range defaults to 10-20
// RULE_02 - software programs range code matching reference
// RULE_03 - software sets range before any readback
// RULE_04 - enable bit level; stays set across measurements
// RULE_05 - restart bit 1-then-0 clears flag, starts measurement
// RULE_06 - done flag 0 while running, 1 when valid
// RULE_07 - measurement takes about 80 ms
// RULE_08 - 23-bit result split high/mid/low registers
// RULE_09 - result = rate * 2^(14+range) / reference
// RULE_10 - ratio accurate within 100 ppm
// RULE_11 - measurement never disturbs lock acquisition
// RULE_12 - software discards results while lock lost
// RULE_13 - never enable lock-to-reference and measurement together
// RULE_14 - flag and result held until next restart; code also clears the flag when enable drops or lock-to-reference is set
`timescale 1ns/10ps
`include "drm_defines.vh"
module drm_rate_meas #(
   parameter MEAS_CYCLES   = `DRM_MEAS_CYCLES,
   parameter DATA_DIV_LOG2 = 0
) (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        cfg_wr_i,
   input  wire [7:0]  cfg_wdata_i,
   input  wire        act_wr_i,
   input  wire [7:0]  act_wdata_i,
   input  wire        data_tick_i,
   input  wire        ref_tick_i,
   input  wire        lock_lost_i,
   output wire [7:0]  rate_config_reg_o,
   output wire [7:0]  action_reg_o,
   output wire        meas_done_o,
   output wire        meas_busy_o,
   output wire        rate_valid_o,
   output wire        mode_conflict_o,
   output wire [7:0]  rate_result_high_o,
   output wire [7:0]  rate_result_mid_o,
   output wire [7:0]  rate_result_low_o
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ARM  = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;
   localparam [1:0] ST_DONE = 2'b11;

   // the parameter is an integer; cut it to the timer width on purpose
   localparam integer            MEAS_LAST_I = MEAS_CYCLES - 1;
   localparam [`DRM_TIMER_W-1:0] MEAS_LAST   = MEAS_LAST_I[`DRM_TIMER_W-1:0];

   reg  [7:0]                 cfg_q;
   reg  [7:0]                 act_q;
   reg                        restart_q;
   reg  [1:0]                 state_q;
   reg  [1:0]                 state_d;
   reg  [1:0]                 range_q;
   reg                        gate_done_q;
   reg                        done_q;
   reg  [`DRM_RESULT_W-1:0]   result_q;
   wire                       fine_en;
   wire                       conflict;
   wire                       restart_rise;
   wire                       restart_fall;
   wire [`DRM_REF_CNT_W-1:0]  gate_len;
   wire [`DRM_REF_CNT_W-1:0]  ref_cnt;
   wire [`DRM_RESULT_W-1:0]   data_cnt;
   wire                       data_sat;
   wire [`DRM_TIMER_W-1:0]    timer_cnt;
   wire                       gate_hit;
   wire                       time_up;
   wire                       cnt_clr;
   wire                       running;
   wire [`DRM_RESULT_W-1:0]   scaled;

   // ****************************************************************
   // software registers
   // ****************************************************************
   // range field resets to the lowest reference range [RULE_01]
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cfg_q     <= `DRM_CFG_RESET;
         act_q     <= `DRM_ACT_RESET;
         restart_q <= 1'b0;
      end else begin
         if (cfg_wr_i) begin
            cfg_q <= cfg_wdata_i;
         end
         if (act_wr_i) begin
            act_q <= act_wdata_i;
         end
         restart_q <= act_q[`DRM_ACT_RESTART];
      end
   end

   assign rate_config_reg_o = cfg_q;
   assign action_reg_o      = act_q;

   // enable is a plain level, nothing clears it between runs [RULE_04]
   // the combined mode is undefined; we just refuse to measure in it [RULE_13]
   assign conflict        = cfg_q[`DRM_CFG_FINE_EN] & cfg_q[`DRM_CFG_LOCKREF_EN];
   assign fine_en         = cfg_q[`DRM_CFG_FINE_EN] & ~conflict;
   assign mode_conflict_o = conflict;

   assign restart_rise = act_q[`DRM_ACT_RESTART] & ~restart_q;
   assign restart_fall = ~act_q[`DRM_ACT_RESTART] & restart_q;

   // ****************************************************************
   // gate length and counters
   // ****************************************************************
   // gate spans 2^(14+range) reference ticks, so the data count is the ratio [RULE_09]
   assign gate_len = {{(`DRM_REF_CNT_W-1){1'b0}}, 1'b1} << (`DRM_GATE_BASE_EXP + range_q);
   assign running  = (state_q == ST_RUN);
   assign cnt_clr  = (state_q == ST_ARM) | (state_q == ST_IDLE);
   assign gate_hit = running & ~gate_done_q & (ref_cnt == gate_len - 1'b1) & ref_tick_i;

   drm_tick_cnt #(
      .W (`DRM_REF_CNT_W)
   ) u_ref_cnt (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clr_i     (cnt_clr),
      .inc_i     (running & ~gate_done_q & ref_tick_i),
      .cnt_o     (ref_cnt),
      .sat_o     ()
   );

   // data ticks counted only inside the gate, both edges exact for 100 ppm [RULE_10]
   drm_tick_cnt #(
      .W (`DRM_RESULT_W)
   ) u_data_cnt (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clr_i     (cnt_clr),
      .inc_i     (running & ~gate_done_q & data_tick_i),
      .cnt_o     (data_cnt),
      .sat_o     (data_sat)
   );

   // run time floor keeps the typical completion near 80 ms [RULE_07]
   drm_tick_cnt #(
      .W (`DRM_TIMER_W)
   ) u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clr_i     (cnt_clr),
      .inc_i     (running),
      .cnt_o     (timer_cnt),
      .sat_o     ()
   );

   assign time_up = (timer_cnt >= MEAS_LAST);

   // prescaled data ticks are scaled back; saturate on overflow
   assign scaled = (data_sat || (DATA_DIV_LOG2 > 0 &&
                    (data_cnt >> (`DRM_RESULT_W - DATA_DIV_LOG2)) != 0)) ?
                   {`DRM_RESULT_W{1'b1}} : (data_cnt << DATA_DIV_LOG2);

   // ****************************************************************
   // control state machine
   // ****************************************************************
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (fine_en && restart_rise) begin
               state_d = ST_ARM;
            end
         end
         ST_ARM: begin
            if (!fine_en) begin
               state_d = ST_IDLE;
            end else if (restart_fall) begin
               state_d = ST_RUN; // [RULE_05]
            end
         end
         ST_RUN: begin
            if (!fine_en) begin
               state_d = ST_IDLE;
            end else if (restart_rise) begin
               state_d = ST_ARM;
            end else if (gate_done_q && time_up) begin
               state_d = ST_DONE;
            end
         end
         default: begin
            if (!fine_en) begin
               state_d = ST_IDLE;
            end else if (restart_rise) begin
               state_d = ST_ARM;
            end
         end
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q     <= ST_IDLE;
         range_q     <= `DRM_RANGE_DEFAULT;
         gate_done_q <= 1'b0;
         done_q      <= 1'b0;
         result_q    <= `DRM_RESULT_RESET;
      end else begin
         state_q <= state_d;
         // range sampled at the start so a mid-run write cannot skew the gate [RULE_03]
         if (state_q == ST_ARM) begin
            range_q <= cfg_q[`DRM_CFG_RANGE_HI:`DRM_CFG_RANGE_LO];
         end
         if (cnt_clr) begin
            gate_done_q <= 1'b0;
         end else if (gate_hit) begin
            gate_done_q <= 1'b1;
         end
         // restart clears the flag, finishing sets it [RULE_05] [RULE_06]
         if (state_d == ST_DONE && state_q == ST_RUN) begin
            done_q <= 1'b1;
         end else if (restart_rise || !fine_en) begin
            done_q <= 1'b0;
         end
         // result loads only at completion and is held afterwards [RULE_14]
         if (state_d == ST_DONE && state_q == ST_RUN) begin
            result_q <= scaled;
         end
      end
   end

   // ****************************************************************
   // status and result
   // ****************************************************************
   assign meas_done_o  = done_q;                            // [RULE_06]
   assign meas_busy_o  = (state_q == ST_ARM) | running;
   // lock status only qualifies the result; nothing here feeds the recovery loop [RULE_11]
   assign rate_valid_o = done_q & ~lock_lost_i;             // [RULE_12]

   assign rate_result_high_o = {1'b0, result_q[22:16]};     // [RULE_08]
   assign rate_result_mid_o  = result_q[15:8];              // [RULE_08]
   assign rate_result_low_o  = result_q[7:0];               // [RULE_08]

endmodule

/* File: core/drm_defines.vh */
// constants for the fine data-rate measurement unit
`ifndef DRM_DEFINES_VH
`define DRM_DEFINES_VH

// ****************************************************************
// register field positions
// ****************************************************************
`define DRM_CFG_RANGE_HI      7
`define DRM_CFG_RANGE_LO      6
`define DRM_CFG_FINE_EN       1
`define DRM_CFG_LOCKREF_EN    0
`define DRM_ACT_RESTART       3
`define DRM_STAT_DONE         2

// ****************************************************************
// reset values
// ****************************************************************
`define DRM_CFG_RESET         8'h00
`define DRM_ACT_RESET         8'h00
`define DRM_RESULT_RESET      23'h00_0000
`define DRM_RANGE_DEFAULT     2'h0

// ****************************************************************
// measurement arithmetic and timing
// ****************************************************************
`define DRM_RESULT_W          23
`define DRM_GATE_BASE_EXP     14
`define DRM_REF_CNT_W         18
`define DRM_TIMER_W           24
`define DRM_MEAS_TIME_MS      80
`define DRM_CLK_MHZ           125
`define DRM_MEAS_CYCLES       (`DRM_MEAS_TIME_MS * 1000 * `DRM_CLK_MHZ)

`endif

/* File: core/drm_tick_cnt.v */
// saturating event counter with synchronous clear
`timescale 1ns/10ps
module drm_tick_cnt #(
   parameter W = 8
) (
   input  wire         ref_clk_i,
   input  wire         rst_i,
   input  wire         clr_i,
   input  wire         inc_i,
   output wire [W-1:0] cnt_o,
   output wire         sat_o
);

   reg  [W-1:0] cnt_q;
   wire [W-1:0] cnt_d;

   // ****************************************************************
   // counter
   // ****************************************************************
   // saturate rather than wrap: a wrapped count would look like a plausible low rate
   assign sat_o = &cnt_q;
   assign cnt_d = clr_i ? {W{1'b0}} :
                  (inc_i && !sat_o) ? cnt_q + {{(W-1){1'b0}}, 1'b1} : cnt_q;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign cnt_o = cnt_q;

endmodule

/* File: sim/drm_rate_meas_sva.sv */
// concurrent checks for the data-rate measurement unit
`timescale 1ns/10ps
module drm_rate_meas_sva #(parameter MEAS_CYCLES = 200) (
   input wire       ref_clk_i,
   input wire       rst_i,
   input wire       ref_tick_i,
   input wire       lock_lost_i,
   input wire [7:0] rate_config_reg_o,
   input wire [7:0] action_reg_o,
   input wire       meas_done_o,
   input wire       meas_busy_o,
   input wire       rate_valid_o,
   input wire       mode_conflict_o,
   input wire [7:0] rate_result_high_o,
   input wire [7:0] rate_result_mid_o,
   input wire [7:0] rate_result_low_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // ref ticks and cycles seen while armed or running
   reg  [31:0] tk_q;
   reg  [31:0] cy_q;
   wire [22:0] res = {rate_result_high_o[6:0], rate_result_mid_o, rate_result_low_o};
   always @(posedge ref_clk_i) begin
      tk_q <= (rst_i || !meas_busy_o) ? 32'h0000_0000 : tk_q + {31'h0, ref_tick_i};
      cy_q <= (rst_i || !meas_busy_o) ? 32'h0000_0000 : cy_q + 32'h0000_0001;
   end
   a_range_default: assert property ($fell(rst_i) |-> rate_config_reg_o[7:6] == 2'h0)
      else $error("range not default after reset");
   a_valid_gate: assert property (rate_valid_o == (meas_done_o && !lock_lost_i))
      else $error("valid flag wrong");
   a_restart_arm: assert property ($rose(action_reg_o[3]) && rate_config_reg_o[1:0] == 2'h2
      |=> meas_busy_o && !meas_done_o) else $error("restart did not arm");
   a_min_time: assert property ($rose(meas_done_o) |-> cy_q >= MEAS_CYCLES - 1)
      else $error("done too early");
   a_gate_len: assert property ($rose(meas_done_o)
      |-> tk_q + 32'h0000_0002 >= (32'h0000_4000 << rate_config_reg_o[7:6]))
      else $error("gate shorter than range");
   a_hold_result: assert property (meas_done_o && $past(meas_done_o) |-> $stable(res))
      else $error("result moved while done");
   a_msb_zero: assert property (rate_result_high_o[7] == 1'b0)
      else $error("result high bit 7 set");
   a_enable_drop: assert property ($fell(rate_config_reg_o[1])
      |-> ##[0:1] (!meas_busy_o && !meas_done_o)) else $error("enable drop no abort");
   a_conflict_flag: assert property (mode_conflict_o == (rate_config_reg_o[1:0] == 2'h3))
      else $error("conflict flag wrong");
   cover property ($rose(meas_done_o));
   cover property ($fell(rate_config_reg_o[1]) && meas_busy_o);
   cover property (meas_done_o && lock_lost_i);
endmodule
bind drm_rate_meas drm_rate_meas_sva #(.MEAS_CYCLES(MEAS_CYCLES)) chk_u (.ref_clk_i, .rst_i,
   .ref_tick_i, .lock_lost_i, .rate_config_reg_o, .action_reg_o, .meas_done_o, .meas_busy_o,
   .rate_valid_o, .mode_conflict_o, .rate_result_high_o, .rate_result_mid_o,
   .rate_result_low_o);

/* File: sim/drm_far_model.sv */
// far-side model: reference and recovered-data tick sources
`timescale 1ns/10ps
module drm_far_model (
   input  wire       ref_clk_i,
   input  wire [3:0] data_period_i,
   input  wire       ref_div_i,
   output reg        data_tick_o = 1'b0,
   output reg        ref_tick_o  = 1'b0
);
   reg [3:0] cnt_q = 4'h0;
   // reference at the system rate or at half of it, inside the accepted span
   always @(posedge ref_clk_i) begin
      ref_tick_o  <= ref_div_i ? ~ref_tick_o : 1'b1;
      cnt_q       <= (cnt_q + 4'h1 >= data_period_i) ? 4'h0 : cnt_q + 4'h1;
      data_tick_o <= (cnt_q == 4'h0);
   end
endmodule

/* File: sim/drm_rate_meas_tb.sv */
// self-checking bench for the data-rate measurement unit
`timescale 1ns/10ps
module drm_rate_meas_tb;
   reg         ref_clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cfg_wr = 1'b0;
   reg         act_wr = 1'b0;
   reg         lock_lost = 1'b0;
   reg         ref_div = 1'b0;
   localparam integer MEAS_CYC = 18000;
   reg  [7:0]  wd = 8'h00;
   reg  [3:0]  per = 4'h3;
   reg  [31:0] r;
   wire        dtk, rtk, done, busy, vld, conf;
   wire [7:0]  cfg_q, act_q, rh, rm, rl;
   integer     mismatches = 0;
   integer     checks = 0;
   integer     seed = 32'hf3f0;
   integer     i;
   always #4 ref_clk_i = ~ref_clk_i;
   drm_far_model far_u (.ref_clk_i, .data_period_i(per), .ref_div_i(ref_div),
      .data_tick_o(dtk), .ref_tick_o(rtk));
   drm_rate_meas #(.MEAS_CYCLES(MEAS_CYC)) dut_u (.ref_clk_i, .rst_i, .cfg_wr_i(cfg_wr),
      .cfg_wdata_i(wd), .act_wr_i(act_wr), .act_wdata_i(wd), .data_tick_i(dtk),
      .ref_tick_i(rtk), .lock_lost_i(lock_lost), .rate_config_reg_o(cfg_q), .action_reg_o(act_q),
      .meas_done_o(done), .meas_busy_o(busy), .rate_valid_o(vld), .mode_conflict_o(conf),
      .rate_result_high_o(rh), .rate_result_mid_o(rm), .rate_result_low_o(rl));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("mismatches %0d checks %0d", mismatches, checks);
         if (mismatches == 0 && checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task wr(input sel, input [7:0] v);
      begin
         @(posedge ref_clk_i);
         cfg_wr <= !sel;
         act_wr <= sel;
         wd <= v;
         @(posedge ref_clk_i);
         cfg_wr <= 1'b0;
         act_wr <= 1'b0;
      end
   endtask
   task restart;
      begin
         wr(1'b1, 8'h08);
         wr(1'b1, 8'h00);
         repeat (3) @(negedge ref_clk_i);
      end
   endtask
   function [22:0] expect_res(input [1:0] rng, input dv, input [3:0] p);
      expect_res = ((23'h00_4000 << rng) << dv) / p;
   endfunction
   task measure(input [1:0] rng, input dv);
      reg [22:0] got;
      reg [22:0] exp;
      integer    n;
      integer    lo;
      begin
         r = $random(seed);
         per     <= 4'h2 + {2'b00, r[1:0]};
         ref_div <= dv;
         wr(1'b0, {rng, 6'h02});
         restart;
         check({cfg_q, act_q}, {rng, 6'h02, 8'h00});
         check(done, 1'b0);
         n = 0;
         while (done !== 1'b1 && n < 40000) begin
            @(negedge ref_clk_i);
            n = n + 1;
         end
         check(done, 1'b1);
         // whichever of run floor and gate ends last sets the time, done one cycle later
         lo = (32'h0000_4000 << rng) << dv;
         lo = (lo > MEAS_CYC) ? lo - 1 : MEAS_CYC - 1;
         check(n >= lo && n <= lo + 1, 1'b1);
         got = {rh[6:0], rm, rl};
         exp = expect_res(rng, dv, per);
         check(got + 23'h1 >= exp && got <= exp + 23'h1, 1'b1);
         check(rh[7], 1'b0);
         for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            @(posedge ref_clk_i) lock_lost <= r[0];
            @(negedge ref_clk_i);
            check(vld, !lock_lost);
            check({rh, rm, rl}, {1'b0, got});
         end
      end
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(negedge ref_clk_i);
      check({cfg_q, act_q, done, busy, vld}, 32'h0000_0000);
      check({rh, rm, rl}, 32'h0000_0000);
      // restart must be ignored while disabled or while both enables clash
      for (i = 0; i < 2; i = i + 1) begin
         wr(1'b0, i ? 8'h03 : 8'h00);
         restart;
         check(busy, 1'b0);
         check(conf, i);
      end
      measure(2'h0, 1'b0);
      measure(2'h1, 1'b0);
      measure(2'h0, 1'b1);
      restart;
      repeat (50) @(negedge ref_clk_i);
      check(busy, 1'b1);
      wr(1'b0, 8'h40);
      repeat (2) @(negedge ref_clk_i);
      check({busy, done}, 2'b00);
      end_of_test;
   end
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      mismatches = mismatches + 1;
      end_of_test;
   end
endmodule
